// [rtl/sfs_flash_spi.sv]
// Serial flash SPI target pin-level signalling core
// Notes on behaviour
// - Each output bit after the first of a frame is shifted onto the data-out line on the clock's fall.
// - Commands, address and data are sampled on each rising clock edge outside a pause.
// - While chip select is high the data output is held in high impedance.
// - Deselected, standby is entered unless an internal cycle still runs.
// - After power-up no command counts until chip select has fallen once.
// - Pause suspends the link without deselect and keeps the bit position.
// - During pause the output floats and input and clock are ignored.
// - Write protect low freezes the protected area set by the level bits.
// - Under write protect the level bits and write-disable bit stay put.
`include "sfs_defines.svh"
module sfs_flash_spi (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic serial_data_in,
  input wire logic write_protect_n,
  input wire logic internal_busy,
  input wire logic status_wr_req,
  input wire logic [7:0] status_wr_data,
  input wire logic [7:0] tx_data,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic standby,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic first_byte,
  output logic protect_level_bit2,
  output logic protect_level_bit1,
  output logic protect_level_bit0,
  output logic status_write_disable
);
  sfs_link_if lnk ();
  logic shift_out;
  logic link_oe;

  sfs_shifter u_shift (
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .hold_n(hold_n),
    .data_in(serial_data_in),
    .data_out(shift_out),
    .lnk(lnk.shifter)
  );

  assign lnk.tx_byte = tx_data;

  // Output driver on the link side: floats when deselected or paused
  assign link_oe = ~cs_n & hold_n;
  assign serial_data_out = shift_out;
  assign serial_data_out_oe = link_oe;

  // Synchronisers into mclk: three stages, change once stages 2 and 3 agree
  logic [2:0] cs_sync_reg;
  logic [2:0] tog_sync_reg;
  logic [2:0] wp_sync_reg;
  logic cs_f_reg;
  logic cs_f_next;
  logic tog_f_reg;
  logic tog_f_next;
  logic wp_f_reg;
  logic wp_f_next;

  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  always_comb begin
    cs_f_next = filt(cs_sync_reg, cs_f_reg);
    tog_f_next = filt(tog_sync_reg, tog_f_reg);
    wp_f_next = filt(wp_sync_reg, wp_f_reg);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Select starts as low so a select held low through reset is no fall
      cs_sync_reg <= 3'h0;
      tog_sync_reg <= 3'h0;
      wp_sync_reg <= 3'h7;
      cs_f_reg <= 1'b0;
      tog_f_reg <= 1'b0;
      wp_f_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      tog_sync_reg <= {tog_sync_reg[1:0], lnk.byte_toggle};
      wp_sync_reg <= {wp_sync_reg[1:0], write_protect_n};
      cs_f_reg <= cs_f_next;
      tog_f_reg <= tog_f_next;
      wp_f_reg <= wp_f_next;
    end
  end

  // Selection state machine
  sfs_pkg::sfs_state_t st_reg;
  sfs_pkg::sfs_state_t st_next;
  logic armed_reg;
  logic armed_next;
  logic first_reg;
  logic first_next;
  logic rxv_reg;
  logic rxv_next;
  logic [7:0] rxd_reg;
  logic [7:0] rxd_next;
  logic stby_reg;
  logic stby_next;
  logic cs_fall;
  logic byte_evt;

  assign cs_fall = cs_f_reg & ~cs_f_next;
  assign byte_evt = tog_f_reg != tog_f_next;

  always_comb begin
    st_next = st_reg;
    armed_next = armed_reg;
    first_next = first_reg;
    rxv_next = 1'b0;
    rxd_next = rxd_reg;
    case (st_reg)
      sfs_pkg::SFS_ST_WAIT_SEL: begin
        // A select already low at power-up is not a falling edge
        if (cs_fall) begin
          st_next = sfs_pkg::SFS_ST_ACTIVE;
          first_next = 1'b1;
        end
      end
      sfs_pkg::SFS_ST_IDLE: begin
        if (cs_fall) begin
          st_next = sfs_pkg::SFS_ST_ACTIVE;
          first_next = 1'b1;
        end
      end
      sfs_pkg::SFS_ST_ACTIVE: begin
        if (byte_evt) begin
          rxv_next = 1'b1;
          rxd_next = lnk.rx_byte;
          first_next = 1'b0;
          // The first byte of a frame carries the first-byte flag
          armed_next = first_reg;
        end
        if (cs_f_next) begin
          st_next = sfs_pkg::SFS_ST_IDLE;
          first_next = 1'b0;
        end
      end
      default: st_next = sfs_pkg::SFS_ST_WAIT_SEL;
    endcase
    // Standby only when deselected and nothing internal is running
    stby_next = cs_f_next & ~internal_busy;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= sfs_pkg::SFS_ST_WAIT_SEL;
      armed_reg <= 1'b0;
      first_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxd_reg <= 8'h00;
      stby_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      armed_reg <= armed_next;
      first_reg <= first_next;
      rxv_reg <= rxv_next;
      rxd_reg <= rxd_next;
      stby_reg <= stby_next;
    end
  end

  // Protection bits: frozen while write protect is low
  logic [2:0] bp_reg;
  logic [2:0] bp_next;
  logic swd_reg;
  logic swd_next;

  always_comb begin
    bp_next = bp_reg;
    swd_next = swd_reg;
    if (status_wr_req && wp_f_reg) begin
      bp_next = status_wr_data[`SFS_BP_LSB +: 3];
      swd_next = status_wr_data[`SFS_SWD_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bp_reg <= `SFS_BP_RESET;
      swd_reg <= `SFS_SWD_RESET;
    end else begin
      bp_reg <= bp_next;
      swd_reg <= swd_next;
    end
  end

  assign standby = stby_reg;
  assign rx_valid = rxv_reg;
  assign rx_data = rxd_reg;
  assign first_byte = armed_reg;
  assign protect_level_bit2 = bp_reg[2];
  assign protect_level_bit1 = bp_reg[1];
  assign protect_level_bit0 = bp_reg[0];
  assign status_write_disable = swd_reg;
endmodule

// [rtl/sfs_defines.svh]
// Constants for the serial flash pin-level signalling block
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH
`define SFS_BITS_PER_BYTE 4'h8
`define SFS_BP_RESET 3'h0
`define SFS_SWD_RESET 1'b0
`define SFS_BP_LSB 2
`define SFS_SWD_BIT 7
`endif

// [rtl/sfs_pkg.sv]
// Types for the serial flash pin-level signalling block
package sfs_pkg;
  typedef enum logic [1:0] {
    SFS_ST_WAIT_SEL,
    SFS_ST_IDLE,
    SFS_ST_ACTIVE
  } sfs_state_t;
  typedef logic [7:0] sfs_byte_t;
endpackage

// [rtl/sfs_link_if.sv]
// Signals passed between the link-clock shifter and the system side
interface sfs_link_if;
  logic byte_toggle;
  sfs_pkg::sfs_byte_t rx_byte;
  sfs_pkg::sfs_byte_t tx_byte;
  modport shifter (output byte_toggle, output rx_byte, input tx_byte);
  modport core (input byte_toggle, input rx_byte, output tx_byte);
endinterface

// [rtl/sfs_shifter.sv]
// Link-clock shift engine: samples input on rise, drives output on fall
module sfs_shifter (
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic data_in,
  output logic data_out,
  sfs_link_if.shifter lnk
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [6:0] sh_reg;
  logic [6:0] sh_next;
  logic tog_reg;
  logic tog_next;
  logic [7:0] rxb_reg;
  logic [7:0] rxb_next;
  logic [7:0] out_reg;
  logic [7:0] out_next;
  logic paused;
  logic fresh_reg;
  logic fresh_next;
  logic [7:0] src;

  assign paused = ~hold_n;

  // Bit position survives a pause; deselect clears it
  always_comb begin
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tog_next = tog_reg;
    rxb_next = rxb_reg;
    if (!paused) begin
      cnt_next = cnt_reg + 3'h1;
      sh_next = {sh_reg[5:0], data_in};
      if (cnt_reg == 3'h7) begin
        rxb_next = {sh_reg, data_in};
        tog_next = ~tog_reg;
      end
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_reg <= 3'h0;
      sh_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
    end
  end

  // Toggle and byte are not cleared on deselect so no event is lost;
  // system reset gives the toggle a known level for the synchroniser
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      tog_reg <= 1'b0;
      rxb_reg <= 8'h00;
    end else begin
      tog_reg <= tog_next;
      rxb_reg <= rxb_next;
    end
  end

  // Output byte reloaded at each byte boundary, shifted on falling edge;
  // before the first fall of a frame the top bit comes straight from the
  // byte to send, as mode 0 has no fall ahead of the first rise
  always_comb begin
    out_next = out_reg;
    fresh_next = fresh_reg;
    src = fresh_reg ? lnk.tx_byte : out_reg;
    if (!paused) begin
      fresh_next = 1'b0;
      if (cnt_reg == 3'h0)
        out_next = lnk.tx_byte;
      else
        out_next = {src[6:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_reg <= 8'h00;
      fresh_reg <= 1'b1;
    end else begin
      out_reg <= out_next;
      fresh_reg <= fresh_next;
    end
  end

  assign data_out = fresh_reg ? lnk.tx_byte[7] : out_reg[7];
  assign lnk.byte_toggle = tog_reg;
  assign lnk.rx_byte = rxb_reg;
endmodule

// [bench/sfs_master.sv]
// Bus master model for the flash link: select, clocking and pause
module sfs_master (
  output logic sclk,
  output logic cs_n,
  output logic hold_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cpol = 1'b0;
  // Starts selected so the bench can probe the power-up lockout
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    hold_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic sel(input logic m);
    cpol = m;
    sclk = m;
    // Deselect must last long enough for the system side to see it
    #96 cs_n = 1'b0;
    #24;
  endtask
  // Released data line shows the inverse so a stale value cannot pass
  task automatic desel;
    #24 cs_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask
  task automatic shift(input int n, input logic [7:0] b,
      output logic [7:0] r);
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      serial_data_in = b[i];
      #24 sclk = 1'b1;
      r[i] = serial_data_out;
      #24;
    end
    sclk = cpol;
  endtask
  task automatic pause;
    hold_n = 1'b0;
    repeat (3) begin
      serial_data_in = ~serial_data_in;
      #24 sclk = ~sclk;
    end
    #24 sclk = 1'b0;
    #24 hold_n = 1'b1;
  endtask
endmodule

// [bench/sfs_flash_spi_chk.sv]
// Assertions on the ports of the flash link signalling core
module sfs_flash_spi_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic write_protect_n,
  input wire logic internal_busy,
  input wire logic status_wr_req,
  input wire logic [7:0] status_wr_data,
  input wire logic serial_data_out_oe,
  input wire logic standby,
  input wire logic rx_valid,
  input wire logic protect_level_bit2,
  input wire logic protect_level_bit1,
  input wire logic protect_level_bit0,
  input wire logic status_write_disable
);
  logic [3:0] pb;
  logic [3:0] wd;
  assign pb = {status_write_disable, protect_level_bit2, protect_level_bit1,
    protect_level_bit0};
  assign wd = {status_wr_data[7], status_wr_data[4:2]};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_oe_desel: assert property (cs_n |-> !serial_data_out_oe)
    else $error("output driven while deselected");
  a_oe_pause: assert property (!hold_n |-> !serial_data_out_oe)
    else $error("output driven while paused");
  a_oe_drive: assert property (!cs_n && hold_n |-> serial_data_out_oe)
    else $error("output not driven while selected");
  a_busy_active: assert property (internal_busy |=> !standby)
    else $error("standby while busy");
  a_sel_active: assert property ((!cs_n) [*6] |-> !standby)
    else $error("standby while selected");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("rx valid longer than one cycle");
  a_wp_frozen: assert property ((!write_protect_n) [*5] ##0 status_wr_req
    |=> $stable(pb)) else $error("protect bits changed");
  a_bp_load: assert property (write_protect_n [*5] ##0 status_wr_req
    |=> pb == $past(wd)) else $error("protect bits not loaded");
  c_rx: cover property (rx_valid);
  c_pause: cover property (!cs_n && !hold_n);
  c_frozen: cover property ((!write_protect_n) [*4] ##0 status_wr_req);
endmodule
bind sfs_flash_spi sfs_flash_spi_chk i_sfs_flash_spi_chk (.*);

// [bench/tb_sfs_flash_spi.sv]
// Self-checking bench for the flash link signalling core
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
  fail_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_sfs_flash_spi;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, busy = 1'b0, req = 1'b0;
  logic [7:0] wd = 8'h00, tx = 8'hA5, r, rxd;
  logic sclk, cs_n, hold_n, sdi, sdo, oe, stby, rxv, fb;
  logic [3:0] bp;
  int fail_count = 0, comparisons = 0, rx_cnt = 0, cyc = 0;
  sfs_master i_sfs_master (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
    .serial_data_in(sdi), .serial_data_out(sdo));
  sfs_flash_spi i_sfs_flash_spi (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .hold_n(hold_n), .serial_data_in(sdi),
    .write_protect_n(wp_n), .internal_busy(busy), .status_wr_req(req),
    .status_wr_data(wd), .tx_data(tx), .serial_data_out(sdo),
    .serial_data_out_oe(oe), .standby(stby), .rx_valid(rxv), .rx_data(rxd),
    .first_byte(fb), .protect_level_bit2(bp[2]),
    .protect_level_bit1(bp[1]), .protect_level_bit0(bp[0]),
    .status_write_disable(bp[3]));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rxv === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
    end
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk_byte(input logic [7:0] b, input int n, input logic f);
    i_sfs_master.shift(8, b, r);
    repeat (8) @(posedge mclk);
    `CHK("rx count", n, rx_cnt)
    `CHK("rx byte", b, rxd)
    `CHK("first byte", f, fb)
    `CHK("tx byte", tx, r)
  endtask
  task automatic wr_status(input logic [7:0] d);
    @(posedge mclk);
    #1 wd = d;
    req = 1'b1;
    @(posedge mclk);
    #1 req = 1'b0;
  endtask
  // Selected through reset with no falling select: the byte must be dropped
  task automatic t_power;
    i_sfs_master.shift(8, 8'h81, r);
    repeat (8) @(posedge mclk);
    `CHK("rx count", 0, rx_cnt)
    i_sfs_master.desel();
    repeat (6) @(posedge mclk);
    `CHK("oe", 1'b0, oe)
    `CHK("standby", 1'b1, stby)
  endtask
  task automatic t_modes;
    for (int m = 0; m < 2; m++) begin
      tx = 8'h5A ^ m[7:0];
      i_sfs_master.sel(m[0]);
      chk_byte(8'hC3, 2 * m + 1, 1'b1);
      chk_byte(8'h3C, 2 * m + 2, 1'b0);
      i_sfs_master.desel();
    end
  endtask
  // Pause mid-byte with noise on clock and data, then a lost partial byte
  task automatic t_hold;
    i_sfs_master.sel(1'b0);
    i_sfs_master.shift(3, 8'h96, r);
    i_sfs_master.pause();
    i_sfs_master.shift(5, 8'hB0, r);
    repeat (8) @(posedge mclk);
    `CHK("held byte", 8'h96, rxd)
    i_sfs_master.desel();
    i_sfs_master.sel(1'b0);
    i_sfs_master.shift(4, 8'hF0, r);
    i_sfs_master.desel();
    i_sfs_master.sel(1'b0);
    chk_byte(8'h69, 6, 1'b1);
    i_sfs_master.desel();
  endtask
  task automatic t_prot;
    wr_status(8'h9C);
    `CHK("protect", 4'hF, bp)
    // Write protect only ever swings at logic level
    wp_n = 1'b0;
    repeat (4) @(posedge mclk);
    wr_status(8'h00);
    wr_status(8'h00);
    `CHK("frozen", 4'hF, bp)
    wp_n = 1'b1;
    repeat (4) @(posedge mclk);
    wr_status(8'h00);
    wr_status(8'h10);
    `CHK("protect", 4'h4, bp)
    busy = 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("standby busy", 1'b0, stby)
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    t_power();
    t_modes();
    t_hold();
    t_prot();
    complete_run();
  end
endmodule
